/* hdl/rstsq_core.sv */
// Reset sequencer with supply monitor, clock option decode and AXI4-Lite registers
//
// Summary of operation
// R01 - External pin, low-voltage and watchdog resets each drive the reset pin.
// R02 - Reset pin is held low throughout the start-up delay.
// R03 - Sequence runs active phase, counted delay, then vector fetch.
// R04 - Option picks a 256 or 4096 cycle start-up delay.
// R05 - Vector is fetched from the two top addresses of memory.
// R06 - Vector fetch lasts exactly two cycles.
// R07 - External low pulse resets the device without a running clock.
// R08 - Low-voltage reset drives the reset pin low for other devices.
// R09 - Watchdog underflow drives the pin low for at least minimum width.
// R10 - Illegal opcode or prefix byte also starts a reset.
// R11 - Low-voltage reset is optional, with three selectable thresholds.
// R12 - Supply warning works only when low-voltage reset is enabled.
// R13 - Supply warning comparator level is readable as live status.
// R14 - Enabled warning interrupt fires on every flag toggle in the run phase only.
// R15 - No rising-edge warning interrupt while the start-up delay runs.
// R16 - Enabling while below threshold fires once now, again at crossing.
// R17 - PLL option doubles oscillator clock, otherwise it is halved.
// R18 - PLL must not be enabled with the internal RC oscillator.
// R19 - Clock source chosen by option: external, crystal ranges, or RC.
// R20 - Crystal oscillators keep running through reset; xtal_osc_enable is held low while rst_n is low.
// R21 - Reset asserts at once; its release is synchronised before counting.
`timescale 1ns/1ps

// Three-stage input synchroniser with agreement filter
module rstsq_sync3 #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // Only the second stage reads the first; a change counts when stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         q      <= INIT;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q <= s3_reg;
         end
      end
   end
endmodule : rstsq_sync3

module rstsq_core import rstsq_pkg::*; (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Open-drain reset pin
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   // Reset sources
   input  wire logic        low_voltage_reset_in,
   input  wire logic        wdg_underflow,
   input  wire logic        illegal_opcode,
   // Non-volatile options
   input  wire logic        opt_startup_long,
   input  wire logic        opt_lvr_enable,
   input  wire logic [1:0]  opt_lvr_level,
   input  wire logic        opt_pll_enable,
   input  wire logic [2:0]  opt_clk_source,
   // Supply warning comparator
   input  wire logic        supply_warning_level_in,
   // CPU side
   output logic             cpu_reset_n,
   output logic             vector_fetch,
   output logic [15:0]      vector_addr,
   output logic             supply_warning_irq,
   // Clock and supervisor controls
   output logic             pll_enable,
   output logic             clk_half_select,
   output logic             xtal_osc_enable,
   output logic             rc_osc_enable,
   output logic             low_voltage_reset_en,
   output logic [1:0]       low_voltage_reset_level,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   rstsq_state_t state_reg;
   rstsq_state_t state_next;
   logic [12:0]  cnt_reg;
   logic [12:0]  cnt_next;
   logic [12:0]  dly_len;
   logic [12:0]  dly_seen_reg;
   logic [2:0]   run_age_reg;
   logic         rst_meta_reg;
   logic         rst_n;
   logic         pin_arst_n;
   logic         cpu_rel1_reg;
   logic         pin_f;
   logic         lvr_f;
   logic         swl_f;
   logic         opt_long_reg;
   logic         opt_lvr_en_reg;
   logic         lvr_on;
   logic         ext_req;
   logic         req_any;
   logic         swf_reg;
   logic         swf_prev_reg;
   logic         irq_en_reg;
   logic         irq_en_prev_reg;
   logic [3:0]   cause_reg;
   logic [3:0]   cause_set;
   logic [3:0]   cause_clr;
   logic [3:0]   aw_addr_reg;
   logic [31:0]  w_data_reg;
   logic [3:0]   w_strb_reg;
   logic         do_write;
   logic [1:0]   phase_code;

   // Core reset: asserts at once, releases two edges after resetn rises
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;                                 // R21
         rst_n        <= rst_meta_reg;
      end
   end

   // Input synchronisers for pin and analog comparator levels
   rstsq_sync3 #(.INIT(1'b1)) u_pin_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (reset_pin_in),
      .q     (pin_f)
   );
   rstsq_sync3 #(.INIT(1'b0)) u_lvr_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (low_voltage_reset_in),
      .q     (lvr_f)
   );
   rstsq_sync3 #(.INIT(1'b0)) u_swl_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (supply_warning_level_in),
      .q     (swl_f)
   );

   // Option capture and clock decode; options are static, so one stage is enough
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opt_long_reg            <= 1'b1;
         opt_lvr_en_reg          <= 1'b0;
         pll_enable              <= 1'b0;
         clk_half_select         <= 1'b1;
         xtal_osc_enable         <= 1'b0;
         rc_osc_enable           <= 1'b0;
         low_voltage_reset_en    <= 1'b0;
         low_voltage_reset_level <= 2'h0;
      end else begin
         opt_long_reg            <= opt_startup_long;                         // R04
         opt_lvr_en_reg          <= opt_lvr_enable;                           // R11
         low_voltage_reset_en    <= opt_lvr_enable;                           // R11
         low_voltage_reset_level <= opt_lvr_level;                            // R11
         // Doubling is refused on the RC source, which cannot feed the PLL safely
         pll_enable              <= opt_pll_enable && opt_clk_source != CLKSRC_RC; // R17 R18
         clk_half_select         <= !opt_pll_enable;                          // R17
         // Crystals run in every phase but stay off while rst_n is low, so sequenced resets pay no restart time
         xtal_osc_enable         <= opt_clk_source != CLKSRC_EXT &&
                                    opt_clk_source != CLKSRC_RC;              // R19 R20
         rc_osc_enable           <= opt_clk_source == CLKSRC_RC;              // R19
      end
   end

   // Reset requests; own pin drive is masked until the pin has settled after release
   assign lvr_on  = lvr_f && opt_lvr_en_reg;                                  // R08 R11
   assign ext_req = !pin_f && state_reg == ST_RUN && run_age_reg == PIN_SETTLE_CYC;
   assign req_any = ext_req || lvr_on || wdg_underflow || illegal_opcode;     // R01 R10
   assign dly_len = opt_long_reg ? STARTUP_LONG_CYC : STARTUP_SHORT_CYC;      // R04

   // Phase sequencing
   always_comb begin
      state_next = state_reg;
      cnt_next   = 13'(cnt_reg + 13'h0001);
      if (req_any) begin
         state_next = ST_ACTIVE;                                              // R01
         cnt_next   = 13'h0000;
      end else begin
         case (state_reg)
            ST_ACTIVE: begin
               if (cnt_reg >= 13'(ACTIVE_MIN_CYC - 13'h0001)) begin           // R09
                  state_next = ST_DELAY;                                      // R03
                  cnt_next   = 13'h0000;
               end
            end
            ST_DELAY: begin
               if (cnt_reg == 13'(dly_len - 13'h0001)) begin                  // R04
                  state_next = ST_FETCH;                                      // R03
                  cnt_next   = 13'h0000;
               end
            end
            ST_FETCH: begin
               if (cnt_reg == 13'(FETCH_CYC - 13'h0001)) begin                // R06
                  state_next = ST_RUN;
               end
            end
            ST_RUN: begin
               cnt_next = cnt_reg;
            end
            default: begin
               state_next = ST_ACTIVE;
               cnt_next   = 13'h0000;
            end
         endcase
      end
   end

   // Phase state and pin drive; the pin stays low in the active and delay phases
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_ACTIVE;
         cnt_reg       <= 13'h0000;
         run_age_reg   <= 3'h0;
         reset_pin_out <= 1'b0;
         reset_pin_oe  <= 1'b1;
         vector_fetch  <= 1'b0;
         vector_addr   <= 16'h0000;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         reset_pin_out <= 1'b0;
         reset_pin_oe  <= state_next == ST_ACTIVE || state_next == ST_DELAY;  // R02 R08 R09
         vector_fetch  <= state_next == ST_FETCH;                             // R06
         if (state_next == ST_FETCH) begin
            vector_addr <= (cnt_next == 13'h0000) ? VEC_ADDR_LO : VEC_ADDR_HI; // R05
         end else begin
            vector_addr <= 16'h0000;
         end
         if (state_next != ST_RUN) begin
            run_age_reg <= 3'h0;
         end else if (run_age_reg != PIN_SETTLE_CYC) begin
            run_age_reg <= 3'(run_age_reg + 3'h1);
         end
      end
   end

   // CPU reset: cleared at once by a low pin even with the clock stopped
   // Two-stage release, so the core runs from the first cycle after the fetch
   assign pin_arst_n = resetn && reset_pin_in;                                // R07
   always_ff @(posedge clk or negedge pin_arst_n) begin
      if (!pin_arst_n) begin
         cpu_rel1_reg <= 1'b0;
         cpu_reset_n  <= 1'b0;
      end else begin
         cpu_rel1_reg <= 1'b1;                                                // R21
         cpu_reset_n  <= cpu_rel1_reg && rst_n && state_next == ST_RUN;       // R06 R21
      end
   end

   // Delay length seen, for checking only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_seen_reg <= 13'h0000;
      end else if (state_reg == ST_ACTIVE) begin
         dly_seen_reg <= 13'h0000;
      end else if (state_reg == ST_DELAY) begin
         dly_seen_reg <= 13'(dly_seen_reg + 13'h0001);
      end
   end

   // Supply warning flag and its toggle interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         swf_reg            <= 1'b0;
         swf_prev_reg       <= 1'b0;
         irq_en_prev_reg    <= 1'b0;
         supply_warning_irq <= 1'b0;
      end else begin
         swf_reg            <= swl_f && opt_lvr_en_reg;                       // R12 R13
         swf_prev_reg       <= swf_reg;
         irq_en_prev_reg    <= irq_en_reg;
         // Toggles during start-up are absorbed by the tracked previous value
         supply_warning_irq <= irq_en_reg &&
                               ((swf_reg != swf_prev_reg && state_reg == ST_RUN) || // R14 R15
                                (!irq_en_prev_reg && swf_reg));                     // R16
      end
   end

   // Reset cause bits: hardware set wins over a software clear
   assign do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign cause_set = {illegal_opcode, wdg_underflow, lvr_on, ext_req};
   assign cause_clr = (do_write && aw_addr_reg == REG_CAUSE && w_strb_reg[0]) ?
                      w_data_reg[3:0] : 4'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_reg <= CAUSE_RST;
      end else begin
         cause_reg <= (cause_reg & ~cause_clr) | cause_set;
      end
   end

   // Phase code for status readback
   always_comb begin
      case (state_reg)
         ST_ACTIVE: phase_code = 2'h0;
         ST_DELAY:  phase_code = 2'h1;
         ST_FETCH:  phase_code = 2'h2;
         ST_RUN:    phase_code = 2'h3;
         default:   phase_code = 2'h0;
      endcase
   end

   // Write channel: address and data taken in either order, answer after both
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr_reg   <= 4'h0;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         irq_en_reg    <= CTRL_IRQ_EN_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            case (aw_addr_reg)
               REG_CTRL: begin
                  if (w_strb_reg[0]) begin
                     irq_en_reg <= w_data_reg[CTRL_IRQ_EN_BIT];
                  end
               end
               REG_STATUS, REG_CAUSE: begin
               end
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read channel: one read at a time, data one edge after the address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL:   s_axi_rdata[CTRL_IRQ_EN_BIT] <= irq_en_reg;
            REG_STATUS: begin
               s_axi_rdata[ST_LEVEL_BIT]                  <= swf_reg;         // R13
               s_axi_rdata[ST_LONG_BIT]                   <= opt_long_reg;
               s_axi_rdata[ST_LVR_EN_BIT]                 <= opt_lvr_en_reg;
               s_axi_rdata[ST_PHASE_LSB + 1:ST_PHASE_LSB] <= phase_code;
            end
            REG_CAUSE:  s_axi_rdata[3:0] <= cause_reg;
            default:    s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Checks
   sequence s_fetch_pair;
      vector_addr == VEC_ADDR_LO ##1 vector_addr == VEC_ADDR_HI;
   endsequence
   sequence s_drive8;
      reset_pin_oe [*8];
   endsequence

   property p_delay_pin;
      @(posedge clk) disable iff (!rst_n) state_reg == ST_DELAY |-> reset_pin_oe;
   endproperty
   a_delay_pin: assert property (p_delay_pin) else $error("pin released in delay"); // R02

   property p_order;
      @(posedge clk) disable iff (!rst_n)
         $rose(vector_fetch) |-> $past(state_reg) == ST_DELAY;
   endproperty
   a_order: assert property (p_order) else $error("fetch not after delay"); // R03

   property p_delay_len;
      @(posedge clk) disable iff (!rst_n) $rose(vector_fetch) |-> dly_seen_reg == dly_len;
   endproperty
   a_delay_len: assert property (p_delay_len) else $error("wrong delay length"); // R04

   property p_vec_addr;
      @(posedge clk) disable iff (!rst_n) $rose(vector_fetch) |-> s_fetch_pair;
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address"); // R05

   property p_fetch_two;
      @(posedge clk) disable iff (!rst_n || req_any)
         $rose(vector_fetch) |-> vector_fetch ##1 vector_fetch ##1 !vector_fetch;
   endproperty
   a_fetch_two: assert property (p_fetch_two) else $error("fetch not two cycles"); // R06

   property p_ext_pin;
      @(posedge clk) disable iff (!rst_n)
         !reset_pin_in && !reset_pin_oe |=> !cpu_reset_n;
   endproperty
   a_ext_pin: assert property (p_ext_pin) else $error("pin low missed"); // R07

   property p_lvr_drive;
      @(posedge clk) disable iff (!rst_n) lvr_on |=> reset_pin_oe && !cpu_reset_n;
   endproperty
   a_lvr_drive: assert property (p_lvr_drive) else $error("lvr not driving pin"); // R08

   property p_wdg_width;
      @(posedge clk) disable iff (!rst_n)
         wdg_underflow |=> s_drive8 ##1 s_drive8 ##1 s_drive8 ##1 reset_pin_oe;
   endproperty
   a_wdg_width: assert property (p_wdg_width) else $error("watchdog pulse short"); // R09

   property p_illegal;
      @(posedge clk) disable iff (!rst_n)
         illegal_opcode |=> state_reg == ST_ACTIVE && !cpu_reset_n;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal opcode ignored"); // R10

   property p_warn_gate;
      @(posedge clk) disable iff (!rst_n) !opt_lvr_en_reg |=> !swf_reg;
   endproperty
   a_warn_gate: assert property (p_warn_gate) else $error("warning without lvr"); // R12

   property p_toggle_irq;
      @(posedge clk) disable iff (!rst_n)
         state_reg == ST_RUN && irq_en_reg && $changed(swf_reg) |-> ##1 supply_warning_irq;
   endproperty
   a_toggle_irq: assert property (p_toggle_irq) else $error("toggle irq missing"); // R14

   property p_no_startup_irq;
      @(posedge clk) disable iff (!rst_n)
         state_reg != ST_RUN && !(irq_en_reg && !irq_en_prev_reg) |=> !supply_warning_irq;
   endproperty
   a_no_startup_irq: assert property (p_no_startup_irq) else $error("irq in start-up"); // R15

   property p_enable_irq;
      @(posedge clk) disable iff (!rst_n)
         $rose(irq_en_reg) && swf_reg |=> supply_warning_irq;
   endproperty
   a_enable_irq: assert property (p_enable_irq) else $error("enable irq missing"); // R16

   property p_cpu_hold;
      @(posedge clk) disable iff (!rst_n) state_reg != ST_RUN |-> !cpu_reset_n;
   endproperty
   a_cpu_hold: assert property (p_cpu_hold) else $error("cpu released early"); // R21

endmodule : rstsq_core

/* inc/rstsq_pkg.sv */
// Constants, register map and state type of the reset sequencer block
package rstsq_pkg;

   // Clock rate and timing of the driven reset pin
   localparam int          CLK_PERIOD_NS     = 20;
   localparam int          TW_RSTL_OUT_NS    = 500;   // Least low time of the driven pin
   localparam int          ACTIVE_MIN_CYC_I  = (TW_RSTL_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [12:0] ACTIVE_MIN_CYC    = 13'(ACTIVE_MIN_CYC_I);

   // Start-up delay lengths and vector fetch
   localparam logic [12:0] STARTUP_SHORT_CYC = 13'h0100;
   localparam logic [12:0] STARTUP_LONG_CYC  = 13'h1000;
   localparam logic [12:0] FETCH_CYC         = 13'h0002;
   localparam logic [15:0] VEC_ADDR_LO       = 16'hfffe;
   localparam logic [15:0] VEC_ADDR_HI       = 16'hffff;
   localparam logic [2:0]  PIN_SETTLE_CYC    = 3'h4;    // Pin sampling lag after release

   // Clock source option codes
   localparam logic [2:0]  CLKSRC_EXT        = 3'h0;
   localparam logic [2:0]  CLKSRC_RC         = 3'h6;

   // Register byte offsets
   localparam logic [3:0]  REG_CTRL          = 4'h0;
   localparam logic [3:0]  REG_STATUS        = 4'h4;
   localparam logic [3:0]  REG_CAUSE         = 4'h8;

   // Field positions
   localparam int          CTRL_IRQ_EN_BIT   = 0;
   localparam int          ST_LEVEL_BIT      = 0;
   localparam int          ST_LONG_BIT       = 1;
   localparam int          ST_LVR_EN_BIT     = 2;
   localparam int          ST_PHASE_LSB      = 4;
   localparam int          CAUSE_EXT_BIT     = 0;
   localparam int          CAUSE_LVR_BIT     = 1;
   localparam int          CAUSE_WDG_BIT     = 2;
   localparam int          CAUSE_ILL_BIT     = 3;

   // Reset values
   localparam logic        CTRL_IRQ_EN_RST   = 1'h0;
   localparam logic [3:0]  CAUSE_RST         = 4'h0;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // Sequencer phases
   typedef enum logic [1:0] {ST_ACTIVE, ST_DELAY, ST_FETCH, ST_RUN} rstsq_state_t;

endpackage : rstsq_pkg

/* bench/rstsq_pin_model.sv */
// Open-drain reset pin with pull-up and an outside reset circuit
`timescale 1ns/1ps
module rstsq_pin_model (
   // Device side of the pad
   input  wire logic reset_pin_oe,
   input  wire logic reset_pin_out,
   // Outside circuit pulling the line
   input  wire logic ext_pull_low,
   // Resolved line level
   output logic      pin_level
);
   // Pull-up wins once every party lets go, so a released line never keeps a stale low
   assign pin_level = (ext_pull_low || (reset_pin_oe && !reset_pin_out)) ? 1'b0 : 1'b1;
endmodule : rstsq_pin_model

/* bench/tb_reset_sequencer_supply_monitor.sv */
// Self-checking bench for the reset sequencer block
`timescale 1ns/1ps
module tb_reset_sequencer_supply_monitor import rstsq_pkg::*;;
   logic clk, resetn, reset_pin_in, reset_pin_out, reset_pin_oe, ext_pull_low;
   logic low_voltage_reset_in, wdg_underflow, illegal_opcode, opt_startup_long;
   logic opt_lvr_enable, opt_pll_enable, supply_warning_level_in, cpu_reset_n, vector_fetch;
   logic supply_warning_irq, pll_enable, clk_half_select, xtal_osc_enable, rc_osc_enable;
   logic low_voltage_reset_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  opt_lvr_level, low_voltage_reset_level, s_axi_bresp, s_axi_rresp;
   logic [2:0]  opt_clk_source;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [15:0] vector_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   int          error_cnt, checks_done, cyc, k;

   rstsq_core i_dut (.*);
   rstsq_pin_model i_pin (.reset_pin_oe(reset_pin_oe), .reset_pin_out(reset_pin_out),
                          .ext_pull_low(ext_pull_low), .pin_level(reset_pin_in));

   // Clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("Mismatches %0d of %0d checks", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // Hang guard, several times the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // Write both channels together, each dropped once taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = {s_axi_rresp, s_axi_rdata[29:0]};
      s_axi_rready <= 1'b0;
   endtask : axr

   // Time the pin hold, then the two-word vector fetch; d below zero skips timing
   task automatic run_seq(input int d);
      int n = 0;
      @(negedge clk);
      while (reset_pin_oe === 1'b1 && n < 5000) begin
         n++;
         @(negedge clk);
      end
      if (d >= 0) chk("hold", 32'(ACTIVE_MIN_CYC_I + d), n);
      chk("fetch0", 32'h0001_fffe, {vector_fetch, vector_addr});
      @(negedge clk);
      chk("fetch1", 32'h0001_ffff, {vector_fetch, vector_addr});
      @(negedge clk);
      chk("run", 32'h0000_0001, {vector_fetch, cpu_reset_n});
      @(posedge clk);
   endtask : run_seq

   // Count warning pulses over a short window
   task automatic cnt_irq();
      k = 0;
      repeat (12) begin
         @(negedge clk);
         k += int'(supply_warning_irq === 1'b1);
      end
      @(posedge clk);
   endtask : cnt_irq

   // Main sequence
   initial begin
      {error_cnt, checks_done, cyc, resetn, ext_pull_low, low_voltage_reset_in} = '0;
      {wdg_underflow, illegal_opcode, opt_startup_long, opt_pll_enable} = '0;
      {supply_warning_level_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {opt_lvr_enable, opt_lvr_level, opt_clk_source, s_axi_wstrb} = 10'b1_10_001_1111;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(negedge clk);
      chk("oe_xtal", 32'h0000_0003, {reset_pin_oe, xtal_osc_enable});
      chk("lvr_opt", 32'h0000_0005, {low_voltage_reset_level, low_voltage_reset_en});
      chk("clk_opt", 32'h0000_0002, {pll_enable, clk_half_select, rc_osc_enable});
      run_seq(-1);
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         {illegal_opcode, wdg_underflow} <= 2'(s + 1);
         @(posedge clk);
         {illegal_opcode, wdg_underflow} <= 2'b00;
         run_seq(256);
      end
      axr(REG_CAUSE, rd);
      chk("cause", 32'h0000_000c, rd);
      axw(REG_CAUSE, 32'h0000_0004);
      axr(REG_CAUSE, rd);
      chk("cause_w1c", 32'h0000_0008, rd);
      axr(4'hc, rd);
      chk("unmapped", {RESP_SLVERR, 30'h0}, rd);
      @(posedge clk);
      ext_pull_low <= 1'b1;
      #1 chk("ext_async", 32'h0, cpu_reset_n);
      repeat (10) @(posedge clk);
      ext_pull_low <= 1'b0;
      run_seq(-1);
      low_voltage_reset_in <= 1'b1;
      repeat (40) @(posedge clk);
      chk("lvr_hold", 32'h2, {reset_pin_oe, cpu_reset_n});
      low_voltage_reset_in <= 1'b0;
      run_seq(-1);
      for (int en = 1; en >= 0; en--) begin
         opt_lvr_enable <= 1'(en);
         axw(REG_CTRL, 32'h0000_0001);
         supply_warning_level_in <= 1'b1;
         cnt_irq();
         chk("irq_fall", en, k);
         axr(REG_STATUS, rd);
         chk("flag", en, rd[ST_LEVEL_BIT]);
         axw(REG_CTRL, 32'h0000_0000);
         axw(REG_CTRL, 32'h0000_0001);
         cnt_irq();
         chk("irq_enable", en, k);
         supply_warning_level_in <= 1'b0;
         cnt_irq();
         chk("irq_rise", en, k);
      end
      opt_startup_long <= 1'b1;
      @(posedge clk);
      wdg_underflow <= 1'b1;
      @(posedge clk);
      wdg_underflow <= 1'b0;
      run_seq(4096);
      {opt_pll_enable, opt_clk_source} <= {1'b1, CLKSRC_RC};
      repeat (2) @(negedge clk);
      chk("clk_rc", 32'h0000_0001, {pll_enable, clk_half_select, xtal_osc_enable, rc_osc_enable});
      @(posedge clk);
      opt_clk_source <= CLKSRC_EXT;
      repeat (2) @(negedge clk);
      chk("clk_pll", 32'h0000_0008, {pll_enable, clk_half_select, xtal_osc_enable, rc_osc_enable});
      tally_and_finish();
   end
endmodule : tb_reset_sequencer_supply_monitor
